// >>> slot_hotplug_pkg.sv
/*
 * constants, register map and state codes for the slot hot-plug
 * configuration block.
 * assumes a 100 MHz core clock and 12-bit axi4-lite byte addresses.
 */
`default_nettype none
package slot_hotplug_pkg;
    localparam int          ADDR_W        = 12;
    localparam logic [11:0] OFF_CONTROL   = 12'h408;
    localparam logic [11:0] OFF_SCRATCH   = 12'h40c;
    localparam logic [11:0] OFF_FUNC      = 12'h418;
    localparam logic [11:0] OFF_STATUS    = 12'h440;
    localparam int          BIT_AUTO_OFF  = 11;
    localparam int          BIT_LOCK_MODE = 12;
    localparam int          BIT_TOGGLE    = 13;
    localparam int          MODE_LSB      = 14;
    localparam int          P2R_LSB       = 16;
    localparam int          R2P_LSB       = 24;
    localparam logic [31:0] CTL_RESET     = 32'h1414_0800;
    localparam logic [31:0] STICKY_MASK   = 32'hffff_f9ff;
    localparam logic [31:0] SCRATCH_RESET = 32'h0000_0000;
    localparam logic [1:0]  MODE_GOOD     = 2'h1;
    localparam logic [1:0]  MODE_HOT      = 2'h2;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
    localparam int          CLOCK_NS      = 10;
    localparam int          TICK_NS       = 10_000_000;
    localparam int          PULSE_NS      = 125_000_000;
    localparam int          TICK_CYCLES   = TICK_NS / CLOCK_NS;
    localparam int          PULSE_CYCLES  = PULSE_NS / CLOCK_NS;
    localparam int          TICK_W        = 24;
    localparam int          PULSE_W       = 27;
    typedef enum logic [3:0] {
        SLOT_OFF   = 4'b0001,
        SLOT_RAMP  = 4'b0010,
        SLOT_ON    = 4'b0100,
        SLOT_DRAIN = 4'b1000
    } slot_state_e;
endpackage : slot_hotplug_pkg
`default_nettype wire

// >>> slot_hotplug_config.sv
/*
 * slot hot-plug configuration: register bank on axi4-lite, pin polarity,
 * slot power and reset sequencing, interlock drive, gpio function mux.
 * assumes pins are asynchronous, core signals and hot_reset are on clock.
 */
`timescale 1ns/1ps
`default_nettype none
module slot_hotplug_config
    import slot_hotplug_pkg::*;
#(
    parameter int PORTS         = 2,
    parameter int GPIO_PINS     = 16,
    parameter int TICK_CYCLES_P = TICK_CYCLES,
    parameter int PULSE_CYCLES_P = PULSE_CYCLES
) (
    input  wire logic                 clock,
    input  wire logic                 rst_b,
    input  wire logic                 hot_reset,
    input  wire logic [ADDR_W-1:0]    awaddr,
    input  wire logic                 awvalid,
    output logic                      awready,
    input  wire logic [31:0]          wdata,
    input  wire logic [3:0]           wstrb,
    input  wire logic                 wvalid,
    output logic                      wready,
    output logic [1:0]                bresp,
    output logic                      bvalid,
    input  wire logic                 bready,
    input  wire logic [ADDR_W-1:0]    araddr,
    input  wire logic                 arvalid,
    output logic                      arready,
    output logic [31:0]               rdata,
    output logic [1:0]                rresp,
    output logic                      rvalid,
    input  wire logic                 rready,
    input  wire logic [PORTS-1:0]     attention_button_in,
    input  wire logic [PORTS-1:0]     presence_detect_in,
    input  wire logic [PORTS-1:0]     power_fault_in,
    input  wire logic [PORTS-1:0]     retention_latch_in,
    input  wire logic [PORTS-1:0]     slot_power_good_in,
    output logic [PORTS-1:0]          attention_indicator_out,
    output logic [PORTS-1:0]          power_indicator_out,
    output logic [PORTS-1:0]          slot_power_enable_out,
    output logic [PORTS-1:0]          interlock_out,
    output logic [PORTS-1:0]          port_reset_out_b,
    input  wire logic [PORTS-1:0]     attention_on,
    input  wire logic [PORTS-1:0]     power_led_on,
    input  wire logic [PORTS-1:0]     power_controller_control,
    input  wire logic [PORTS-1:0]     latch_present_cap,
    input  wire logic [PORTS-1:0]     interlock_command,
    output logic [PORTS-1:0]          button_pressed,
    output logic [PORTS-1:0]          card_present,
    output logic [PORTS-1:0]          power_fault,
    output logic [PORTS-1:0]          latch_open,
    output logic [PORTS-1:0]          lock_engaged,
    output logic [PORTS-1:0]          power_good,
    input  wire logic [GPIO_PINS-1:0] gpio_out,
    input  wire logic [GPIO_PINS-1:0] gpio_oe,
    input  wire logic [GPIO_PINS-1:0] alt_out,
    input  wire logic [GPIO_PINS-1:0] alt_oe,
    output logic [GPIO_PINS-1:0]      pin_out,
    output logic [GPIO_PINS-1:0]      pin_oe
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic                          awready;
        logic                          wready;
        logic                          bvalid;
        logic [1:0]                    bresp;
        logic                          arready;
        logic                          rvalid;
        logic [1:0]                    rresp;
        logic [31:0]                   rdata;
        logic                          aw_have;
        logic                          w_have;
        logic [ADDR_W-1:0]             aw_addr;
        logic [31:0]                   w_data;
        logic [3:0]                    w_strb;
        logic [31:0]                   ctl;
        logic [31:0]                   scratch;
        logic [GPIO_PINS-1:0]          func;
        logic [5*PORTS-1:0]            sync1;
        logic [5*PORTS-1:0]            sync2;
        logic [PORTS-1:0]              button;
        logic [PORTS-1:0]              presence;
        logic [PORTS-1:0]              fault;
        logic [PORTS-1:0]              latch_open;
        logic [PORTS-1:0]              lock;
        logic [PORTS-1:0]              good;
        logic [PORTS-1:0]              attn_o;
        logic [PORTS-1:0]              led_o;
        logic [PORTS-1:0]              pwr_o;
        logic [PORTS-1:0]              ilock_o;
        logic [PORTS-1:0]              rst_o_b;
        logic [PORTS-1:0]              pwr_en;
        logic [PORTS-1:0]              ilock;
        slot_state_e [PORTS-1:0]       st;
        logic [PORTS-1:0][7:0]         delay;
        logic [PORTS-1:0][PULSE_W-1:0] pulse;
        logic [TICK_W-1:0]             tick_cnt;
        logic                          tick;
        logic [GPIO_PINS-1:0]          pin_o;
        logic [GPIO_PINS-1:0]          pin_oe;
    } state_s;

    state_s            s_reg;
    state_s            s_next;
    logic              wr_fire;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0]       wr_data;
    logic [3:0]        wr_strb;
    logic [PORTS-1:0]  kill;

    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] data,
        input logic [3:0]  strb
    );
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = data[8*b +: 8];
            end
        end
        return r;
    endfunction : merge

    assign kill = {PORTS{s_reg.ctl[BIT_AUTO_OFF]}} & latch_present_cap
                  & s_reg.latch_open;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [1:0]  mode;
        logic        want;
        logic        stable;
        logic [31:0] rd;
        logic        rd_ok;
        s_next  = s_reg;
        mode    = s_reg.ctl[MODE_LSB +: 2];
        want    = 1'b0;
        stable  = 1'b0;
        rd      = 32'h0000_0000;
        rd_ok   = 1'b1;
        wr_fire = 1'b0;

        // write channel: address and data taken in either order
        if (s_reg.bvalid && bready) begin
            s_next.bvalid = 1'b0;
        end
        if (s_reg.awready && awvalid) begin
            s_next.aw_have = 1'b1;
            s_next.aw_addr = awaddr;
        end
        if (s_reg.wready && wvalid) begin
            s_next.w_have = 1'b1;
            s_next.w_data = wdata;
            s_next.w_strb = wstrb;
        end
        wr_addr = {s_next.aw_addr[ADDR_W-1:2], 2'b00};
        wr_data = s_next.w_data;
        wr_strb = s_next.w_strb;
        if (s_next.aw_have && s_next.w_have && !s_next.bvalid) begin
            wr_fire        = 1'b1;
            s_next.aw_have = 1'b0;
            s_next.w_have  = 1'b0;
            s_next.bvalid  = 1'b1;
            s_next.bresp   = RESP_OKAY;
            case (wr_addr)
                OFF_CONTROL: s_next.ctl = merge(s_reg.ctl, wr_data, wr_strb);
                OFF_SCRATCH: begin
                    s_next.scratch = merge(s_reg.scratch, wr_data, wr_strb);
                end
                OFF_FUNC: begin
                    s_next.func = GPIO_PINS'(merge(32'(s_reg.func),
                                                   wr_data, wr_strb));
                end
                OFF_STATUS: s_next.bresp = RESP_SLVERR;
                default:    s_next.bresp = RESP_SLVERR;
            endcase
        end
        s_next.awready = !s_next.aw_have && !s_next.bvalid;
        s_next.wready  = !s_next.w_have && !s_next.bvalid;

        // read channel
        case ({araddr[ADDR_W-1:2], 2'b00})
            OFF_CONTROL: rd = s_reg.ctl;
            OFF_SCRATCH: rd = s_reg.scratch;
            OFF_FUNC:    rd = 32'(s_reg.func);
            OFF_STATUS: begin
                for (int i = 0; i < PORTS; i++) begin
                    rd[8*i +: 8] = {s_reg.st[i], s_reg.good[i],
                                    s_reg.ilock[i], s_reg.rst_o_b[i],
                                    s_reg.pwr_en[i]};
                end
            end
            default: rd_ok = 1'b0;
        endcase
        if (s_reg.rvalid && rready) begin
            s_next.rvalid = 1'b0;
        end
        if (s_reg.arready && arvalid) begin
            s_next.rvalid = 1'b1;
            s_next.rdata  = rd;
            s_next.rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
        end
        s_next.arready = !s_next.rvalid;

        // ------------------------------------------------------------
        // pin inputs
        // ------------------------------------------------------------
        s_next.sync1 = {slot_power_good_in, retention_latch_in,
                        power_fault_in, presence_detect_in,
                        attention_button_in};
        s_next.sync2 = s_reg.sync1;
        s_next.button   = ~s_reg.sync2[0 +: PORTS] ^ {PORTS{s_reg.ctl[0]}};
        s_next.presence = ~s_reg.sync2[PORTS +: PORTS]
                          ^ {PORTS{s_reg.ctl[1]}};
        s_next.fault    = ~s_reg.sync2[2*PORTS +: PORTS]
                          ^ {PORTS{s_reg.ctl[2]}};
        s_next.good     = ~s_reg.sync2[4*PORTS +: PORTS]
                          ^ {PORTS{s_reg.ctl[8]}};
        if (s_reg.ctl[BIT_LOCK_MODE]) begin
            s_next.lock       = ~s_reg.sync2[3*PORTS +: PORTS]
                                ^ {PORTS{s_reg.ctl[3]}};
            s_next.latch_open = '0;
        end else begin
            s_next.latch_open = ~s_reg.sync2[3*PORTS +: PORTS]
                                ^ {PORTS{s_reg.ctl[3]}};
            s_next.lock       = '0;
        end

        // ------------------------------------------------------------
        // ten millisecond tick
        // ------------------------------------------------------------
        // tick divider
        s_next.tick = 1'b0;
        if (s_reg.tick_cnt >= TICK_W'(TICK_CYCLES_P - 1)) begin
            s_next.tick_cnt = '0;
            s_next.tick     = 1'b1;
        end else begin
            s_next.tick_cnt = s_reg.tick_cnt + TICK_W'(1);
        end

        // ------------------------------------------------------------
        // per-port power, reset and interlock
        // ------------------------------------------------------------
        for (int i = 0; i < PORTS; i++) begin
            want   = !power_controller_control[i] && !kill[i];
            // stable follows good only in good mode; delay is +-1 tick
            stable = (mode == MODE_GOOD) ? s_reg.good[i] : 1'b1;
            case (s_reg.st[i])
                SLOT_OFF: begin
                    if (want) begin
                        s_next.st[i]    = SLOT_RAMP;
                        s_next.delay[i] = s_reg.ctl[P2R_LSB +: 8];
                    end
                end
                SLOT_RAMP: begin
                    if (!want) begin
                        s_next.st[i]    = SLOT_DRAIN;
                        s_next.delay[i] = s_reg.ctl[R2P_LSB +: 8];
                    end else if (!stable) begin
                        s_next.delay[i] = s_reg.ctl[P2R_LSB +: 8];
                    end else if (s_reg.delay[i] == 8'h00) begin
                        s_next.st[i] = SLOT_ON;
                    end else if (s_reg.tick) begin
                        s_next.delay[i] = s_reg.delay[i] - 8'h01;
                    end
                end
                SLOT_ON: begin
                    if (!want) begin
                        s_next.st[i]    = SLOT_DRAIN;
                        s_next.delay[i] = s_reg.ctl[R2P_LSB +: 8];
                    end
                end
                SLOT_DRAIN: begin
                    if (s_reg.delay[i] == 8'h00) begin
                        s_next.st[i] = SLOT_OFF;
                    end else if (s_reg.tick) begin
                        s_next.delay[i] = s_reg.delay[i] - 8'h01;
                    end
                end
                default: s_next.st[i] = SLOT_OFF;
            endcase
            s_next.pwr_en[i] = (s_next.st[i] != SLOT_OFF);
            if (mode == MODE_HOT) begin
                s_next.rst_o_b[i] = !hot_reset;
            end else begin
                s_next.rst_o_b[i] = (s_next.st[i] == SLOT_ON);
            end
            if (s_reg.ctl[BIT_TOGGLE]) begin
                s_next.pulse[i] = '0;
                if (interlock_command[i]) begin
                    s_next.ilock[i] = !s_reg.ilock[i];
                end
            end else if (interlock_command[i]) begin
                s_next.pulse[i] = PULSE_W'(PULSE_CYCLES_P - 1);
                s_next.ilock[i] = 1'b1;
            end else if (s_reg.pulse[i] != '0) begin
                s_next.pulse[i] = s_reg.pulse[i] - PULSE_W'(1);
                s_next.ilock[i] = 1'b1;
            end else begin
                s_next.ilock[i] = 1'b0;
            end
        end

        if (hot_reset) begin
            s_next.ctl     = s_next.ctl & STICKY_MASK;
            s_next.scratch = SCRATCH_RESET;
            s_next.ilock   = '0;
            s_next.pulse   = '0;
        end

        // ------------------------------------------------------------
        // pin outputs
        // ------------------------------------------------------------
        // attention led polarity
        s_next.attn_o  = ~(attention_on ^ {PORTS{s_reg.ctl[4]}});
        s_next.led_o   = ~(power_led_on ^ {PORTS{s_reg.ctl[5]}});
        s_next.pwr_o   = s_next.pwr_en ^ {PORTS{s_reg.ctl[6]}};
        s_next.ilock_o = s_next.ilock ^ {PORTS{s_reg.ctl[7]}};
        s_next.pin_o   = (s_reg.func & alt_out) | (~s_reg.func & gpio_out);
        s_next.pin_oe  = (s_reg.func & alt_oe) | (~s_reg.func & gpio_oe);
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s_reg         <= '0;
            s_reg.ctl     <= CTL_RESET;
            s_reg.scratch <= SCRATCH_RESET;
            s_reg.st      <= {PORTS{SLOT_OFF}};
            s_reg.attn_o  <= '1;
            s_reg.led_o   <= '1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign awready                 = s_reg.awready;
    assign wready                  = s_reg.wready;
    assign bvalid                  = s_reg.bvalid;
    assign bresp                   = s_reg.bresp;
    assign arready                 = s_reg.arready;
    assign rvalid                  = s_reg.rvalid;
    assign rdata                   = s_reg.rdata;
    assign rresp                   = s_reg.rresp;
    assign attention_indicator_out = s_reg.attn_o;
    assign power_indicator_out     = s_reg.led_o;
    assign slot_power_enable_out   = s_reg.pwr_o;
    assign interlock_out           = s_reg.ilock_o;
    assign port_reset_out_b        = s_reg.rst_o_b;
    assign button_pressed          = s_reg.button;
    assign card_present            = s_reg.presence;
    assign power_fault             = s_reg.fault;
    assign latch_open              = s_reg.latch_open;
    assign lock_engaged            = s_reg.lock;
    assign power_good              = s_reg.good;
    assign pin_out                 = s_reg.pin_o;
    assign pin_oe                  = s_reg.pin_oe;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [1:0] up_cnt;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            up_cnt <= 2'h0;
        end else if (up_cnt != 2'h3) begin
            up_cnt <= up_cnt + 2'h1;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    sequence held_high_s;
        s_reg.ilock[0] [*8];
    endsequence

    button_sense_a: assert property (
        up_cnt == 2'h3 |-> button_pressed ==
            ($past(~attention_button_in, 3) ^ {PORTS{$past(s_reg.ctl[0])}}))
        else $error("button sense wrong");
    led_polarity_a: assert property (
        up_cnt != 2'h0 |-> power_indicator_out ==
            ~($past(power_led_on) ^ {PORTS{$past(s_reg.ctl[5])}}))
        else $error("power led polarity wrong");
    latch_off_a: assert property (
        s_reg.st[0] == SLOT_ON && kill[0] |=> s_reg.st[0] == SLOT_DRAIN)
        else $error("open latch did not drop power");
    pulse_hold_a: assert property (
        interlock_command[0] && !s_reg.ctl[BIT_TOGGLE] && !hot_reset
            |=> held_high_s)
        else $error("interlock pulse too short");
    toggle_flip_a: assert property (
        interlock_command[0] && s_reg.ctl[BIT_TOGGLE] && !hot_reset
            |=> s_reg.ilock[0] != $past(s_reg.ilock[0]))
        else $error("interlock did not toggle");
    hot_source_a: assert property (
        s_reg.ctl[MODE_LSB +: 2] == MODE_HOT && hot_reset
            |=> !port_reset_out_b[0])
        else $error("hot reset not on port reset");
    ramp_wait_a: assert property (
        s_reg.st[0] == SLOT_RAMP && s_reg.delay[0] != 8'h00
            |=> s_reg.st[0] != SLOT_ON)
        else $error("reset released before delay");
    scratch_write_a: assert property (
        wr_fire && wr_addr == OFF_SCRATCH && wr_strb == 4'hf && !hot_reset
            |=> s_reg.scratch == $past(wr_data))
        else $error("scratch write lost");
    sticky_keep_a: assert property (
        hot_reset && !wr_fire |=> s_reg.scratch == SCRATCH_RESET
            && s_reg.ctl[8:0] == $past(s_reg.ctl[8:0]))
        else $error("hot reset disturbed sticky");

endmodule : slot_hotplug_config
`default_nettype wire

// >>> slot_model.sv
/* slot model: the rail reports good one cycle after enable.
   assumes the power enable is active high (its invert bit clear). */
`timescale 1ns/1ps
`default_nettype none
module slot_model (
    input  wire logic       clock,
    input  wire logic [1:0] slot_power_enable_out,
    output logic      [1:0] slot_power_good_in
);
    logic [1:0] settle_reg;
    // good pin is active low and rises at once when power goes
    always_ff @(posedge clock) settle_reg <= slot_power_enable_out;
    assign slot_power_good_in = ~(settle_reg & slot_power_enable_out);
endmodule : slot_model
`default_nettype wire

// >>> test_slot_hotplug_config.sv
/* bench: axi4-lite tasks, pin stimulus, expected values.
   assumes slot_model drives the power good pins. */
`timescale 1ns/1ps
`default_nettype none
module test_slot_hotplug_config import slot_hotplug_pkg::*;;
logic clock = 1'b0, rst_b = 1'b0, hot_reset = 1'b0;
logic [11:0] awaddr = 12'h0, araddr = 12'h0;
logic [31:0] wdata = 32'h0, rdata, v;
logic [3:0] wstrb = 4'hf;
logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
logic rready = 1'b0, awready, wready, bvalid, arready, rvalid;
logic [1:0] bresp, rresp, rs;
logic [1:0] attention_button_in = 2'h3, presence_detect_in = 2'h0;
logic [1:0] power_fault_in = 2'h3, retention_latch_in = 2'h3;
logic [1:0] attention_on = 2'h3, power_led_on = 2'h0;
logic [1:0] power_controller_control = 2'h3, latch_present_cap = 2'h0;
logic [1:0] interlock_command = 2'h0, slot_power_good_in;
logic [1:0] attention_indicator_out, power_indicator_out, interlock_out;
logic [1:0] slot_power_enable_out, port_reset_out_b, button_pressed;
logic [1:0] card_present, power_fault, latch_open, lock_engaged, power_good;
logic [15:0] gpio_out = 16'h00ff, gpio_oe = 16'h0f0f, pin_out, pin_oe;
logic [15:0] alt_out = 16'hff00, alt_oe = 16'hf0f0;
int n_fail = 0, checks = 0;
always #5 clock = ~clock;
slot_hotplug_config #(.TICK_CYCLES_P(10), .PULSE_CYCLES_P(16))
    u_slot_hotplug_config (.*);
slot_model u_slot_model (.*);
task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
        n_fail++;
        $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
endtask : chk
// sampled at the falling edge: the handshake lands on the next rise
task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
    bready <= 1'b1;
    repeat (40) begin
        @(negedge clock); ta = awready; tw = wready; tb = bvalid;
        @(posedge clock);
        if (ta) awvalid <= 1'b0;
        if (tw) wvalid <= 1'b0;
        if (tb) begin
            bready <= 1'b0;
            @(posedge clock);
            return;
        end
    end
    n_fail++;
endtask : wr
task automatic rd(input logic [11:0] a);
    logic ta, tr;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    repeat (40) begin
        @(negedge clock); ta = arready; tr = rvalid; v = rdata; rs = rresp;
        @(posedge clock);
        if (ta) arvalid <= 1'b0;
        if (tr) begin
            rready <= 1'b0;
            @(posedge clock);
            return;
        end
    end
    n_fail++;
endtask : rd
task automatic pins(input logic [9:0] e);
    repeat (5) @(posedge clock);
    chk(32'({button_pressed, card_present, power_fault,
             attention_indicator_out, power_indicator_out}), 32'(e));
endtask : pins
task automatic ilock(input logic [1:0] a, input int n, input logic [1:0] b);
    interlock_command <= 2'h1;
    @(posedge clock); interlock_command <= 2'h0;
    repeat (2) @(posedge clock); chk(32'(interlock_out), 32'(a));
    repeat (n) @(posedge clock); chk(32'(interlock_out), 32'(b));
endtask : ilock
task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
endtask : finish_test
// far longer than the tests need
initial begin #200us; n_fail++; finish_test; end
initial begin
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    repeat (2) @(posedge clock);
    rd(OFF_CONTROL); chk(v, CTL_RESET);
    rd(OFF_SCRATCH); chk(v, 32'h0);
    rd(OFF_FUNC); chk(v, 32'h0);
    rd(12'h400); chk(32'(rs), 32'(RESP_SLVERR));
    wr(OFF_SCRATCH, 32'ha5c3_0f1e); rd(OFF_SCRATCH); chk(v, 32'ha5c3_0f1e);
    wr(OFF_CONTROL, CTL_RESET | 32'h37);
    pins(10'b11_00_11_11_00);
    hot_reset <= 1'b1; @(posedge clock); hot_reset <= 1'b0;
    rd(OFF_SCRATCH); chk(v, 32'h0);
    rd(OFF_CONTROL); chk(v, CTL_RESET | 32'h37);
    wr(OFF_CONTROL, CTL_RESET);
    pins(10'b00_11_00_00_11);
    $display("test polarity and scratch done");
    wr(OFF_FUNC, 32'hffff_f0f0); rd(OFF_FUNC); chk(v, 32'h0000_f0f0);
    chk({pin_out, pin_oe}, 32'hf00f_ffff);
    wr(OFF_CONTROL, CTL_RESET | 32'h2000);
    ilock(2'h1, 20, 2'h1);
    ilock(2'h0, 1, 2'h0);
    wr(OFF_CONTROL, CTL_RESET);
    ilock(2'h1, 20, 2'h0);
    $display("test gpio and interlock done");
    // power to reset 2 ticks, reset to power off 1 tick, tick 10 cycles
    wr(OFF_CONTROL, 32'h0102_0800);
    power_controller_control <= 2'h0;
    repeat (12) @(posedge clock); chk(32'(port_reset_out_b), 32'h0);
    repeat (30) @(posedge clock); chk(32'(port_reset_out_b), 32'h3);
    chk(32'(slot_power_enable_out), 32'h3);
    power_controller_control <= 2'h3;
    repeat (3) @(posedge clock);
    chk(32'({port_reset_out_b, slot_power_enable_out}), 32'h3);
    repeat (25) @(posedge clock); chk(32'(slot_power_enable_out), 32'h0);
    power_controller_control <= 2'h0;
    repeat (40) @(posedge clock);
    latch_present_cap <= 2'h1; retention_latch_in <= 2'h2;
    repeat (30) @(posedge clock); chk(32'(slot_power_enable_out), 32'h2);
    chk(32'(latch_open), 32'h1);
    $display("test slot power done");
    wr(OFF_CONTROL, CTL_RESET | 32'h1000);
    repeat (5) @(posedge clock);
    chk(32'({lock_engaged, latch_open}), 32'h4);
    chk(32'({power_good, interlock_out}), 32'hc);
    wr(OFF_CONTROL, CTL_RESET | 32'h1180);
    repeat (5) @(posedge clock);
    chk(32'({power_good, interlock_out}), 32'h3);
    wr(OFF_CONTROL, CTL_RESET | 32'h8000);
    hot_reset <= 1'b1;
    repeat (2) @(posedge clock);
    chk(32'(port_reset_out_b), 32'h0);
    hot_reset <= 1'b0;
    repeat (2) @(posedge clock);
    chk(32'(port_reset_out_b), 32'h3);
    wr(OFF_STATUS, 32'h0);
    chk(32'(bresp), 32'(RESP_SLVERR));
    $display("test lock, sense and reset source done");
    finish_test;
end
endmodule : test_slot_hotplug_config
`default_nettype wire
